// *** verilog/sslc_pkg.sv ***
// Purpose: constants and types for the serial segment LCD controller
// Assumes: serial pins and the display oscillator are sampled by ref_clk
// Notes:   command opcodes sit in the top three bits of a command word
package sslc_pkg;
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned ADDR_BITS = 5;
  localparam int unsigned NIB_BITS  = 4;
  localparam int unsigned RAM_DEPTH = 32;
  localparam int unsigned NUM_COM   = 4;
  localparam int unsigned NUM_SEG   = 32;
  localparam int unsigned BUF_DEPTH = 2;

  localparam logic [2:0] OP_ADDR_SET = 3'h0;
  localparam logic [2:0] OP_DISP_ON  = 3'h1;
  localparam logic [2:0] OP_DISP_OFF = 3'h2;
  localparam logic [2:0] OP_DISP_RUN = 3'h3;
  localparam logic [2:0] OP_REWRITE  = 3'h4;
  localparam logic [2:0] OP_RESET    = 3'h6;

  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [4:0] ADDR_RST    = 5'h00;
  localparam logic [4:0] ADDR_ONE    = 5'h01;
  localparam logic [3:0] COM_RST     = 4'h1;

  typedef enum logic [1:0] {
    SSLC_OFF,
    SSLC_ALL_ON,
    SSLC_FROM_RAM
  } sslc_mode_e;

  typedef enum logic {
    SSLC_IDLE,
    SSLC_LOW_NIB
  } sslc_drain_e;
endpackage

// *** verilog/sslc_top.sv ***
// Purpose: serial segment LCD controller core (receiver, decoder, RAM, drive)
// Assumes: all pins asynchronous to ref_clk; shift clock well below ref_clk / 4
// Notes:   drive outputs are logic levels; bias voltages live outside
//          checks sit beside the logic that they guard, apart from those gathered under Checks at the end
`timescale 1ns/1ps
`default_nettype none
module sslc_top
  import sslc_pkg::*;
#(
  parameter int unsigned DEPTH = sslc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // Serial host port
  input  wire logic                         sck,
  input  wire logic                         cs_n,
  input  wire logic                         cd_sel,
  input  wire logic                         serial_in,
  // Display oscillator
  input  wire logic                         osc_in,
  output logic                              osc_out,
  // Word buffer status
  output logic                              buf_ready,
  // LCD drive
  output logic [sslc_pkg::NUM_COM-1:0]      common_outputs,
  output logic [sslc_pkg::NUM_SEG-1:0]      segment_outputs,
  output logic [sslc_pkg::ADDR_BITS-1:0]    address_counter_bits
);
  import sslc_pkg::*;

  // Input synchronisers; the third stage only feeds edge detection
  logic [2:0] sck_q;
  logic [1:0] cs_q;
  logic [1:0] cd_q;
  logic [1:0] sd_q;
  logic [2:0] osc_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 3'h0;
      cs_q  <= 2'h3;
      cd_q  <= 2'h0;
      sd_q  <= 2'h0;
      osc_q <= 3'h0;
    end else begin
      sck_q <= {sck_q[1:0], sck};
      cs_q  <= {cs_q[0], cs_n};
      cd_q  <= {cd_q[0], cd_sel};
      sd_q  <= {sd_q[0], serial_in};
      osc_q <= {osc_q[1:0], osc_in};
    end
  end

  logic sck_rise;
  logic osc_rise;
  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign osc_rise = osc_q[1] & ~osc_q[2];

  // Serial receiver
  logic [2:0]           bit_cnt_q;
  logic [WORD_BITS-1:0] shift_q;
  logic                 push;
  logic [WORD_BITS-1:0] rx_word;

  assign rx_word = {shift_q[WORD_BITS-2:0], sd_q[1]};
  assign push    = sck_rise && !cs_q[1] && (bit_cnt_q == BIT_LAST);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
    end else if (cs_q[1]) begin
      // Deselect drops a partial word, so the next select starts at bit 0
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      shift_q   <= rx_word;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  a_sck_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sck_rise |=> shift_q == $past(shift_q))
    else $error("shift register moved without a shift clock edge");

  // Two-entry word buffer; a word that meets a full buffer is lost,
  // which buf_ready lets the host see
  logic [WORD_BITS:0]           buf_mem [DEPTH];
  logic [$clog2(DEPTH)-1:0]     wr_ptr_q;
  logic [$clog2(DEPTH)-1:0]     rd_ptr_q;
  logic [$clog2(DEPTH+1)-1:0]   count_q;
  logic                         buf_full;
  logic                         buf_valid;
  logic                         pop;
  logic                         do_push;
  logic [WORD_BITS:0]           head;

  assign buf_full  = (count_q == DEPTH[$clog2(DEPTH+1)-1:0]);
  assign buf_valid = (count_q != '0);
  assign do_push   = push && !buf_full;
  assign head      = buf_mem[rd_ptr_q];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        buf_mem[i] <= '0;
      end
    end else begin
      if (do_push) begin
        buf_mem[wr_ptr_q] <= {cd_q[1], rx_word};
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      case ({do_push, pop})
        2'b10:   count_q <= count_q + 1'b1;
        2'b01:   count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_ready <= 1'b1;
    end else begin
      buf_ready <= !(count_q == DEPTH - 1 && do_push && !pop) && !(buf_full && !pop);
    end
  end

  // Ready is a registered look-ahead, so it already counts the word in flight
  a_buf_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    count_q <= DEPTH[$clog2(DEPTH+1)-1:0])
    else $error("word buffer count beyond its depth");
  a_ready_room: assert property (@(posedge ref_clk) disable iff (!rst_n)
    buf_ready |-> !buf_full)
    else $error("ready shown while the word buffer is full");

  // Decoder and display RAM
  sslc_drain_e          drain_q;
  sslc_mode_e           mode_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic [NIB_BITS-1:0]  low_nib_q;
  logic [NIB_BITS-1:0]  display_ram [RAM_DEPTH];
  logic                 is_cmd;
  logic [2:0]           opcode;

  // Drain stalls while the second nibble of a data word is written
  assign pop    = buf_valid && (drain_q == SSLC_IDLE);
  assign is_cmd = head[WORD_BITS];
  assign opcode = head[7:5];

  // Command decode shared by the RAM write and the checks
  function automatic logic is_op(input logic [WORD_BITS:0] w, input logic [2:0] op);
    return w[WORD_BITS] && (w[7:5] == op);
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_q   <= SSLC_IDLE;
      mode_q    <= SSLC_OFF;
      addr_q    <= ADDR_RST;
      low_nib_q <= 4'h0;
    end else begin
      case (drain_q)
        SSLC_IDLE: begin
          if (pop && !is_cmd) begin
            low_nib_q <= head[3:0];
            addr_q    <= addr_q + ADDR_ONE;
            drain_q   <= SSLC_LOW_NIB;
          end else if (pop) begin
            case (opcode)
              OP_ADDR_SET: addr_q <= head[4:0];
              OP_DISP_ON:  mode_q <= SSLC_ALL_ON;
              OP_DISP_OFF: mode_q <= SSLC_OFF;
              OP_DISP_RUN: mode_q <= SSLC_FROM_RAM;
              OP_REWRITE:  addr_q <= addr_q + ADDR_ONE;
              OP_RESET: begin
                mode_q <= SSLC_OFF;
                addr_q <= ADDR_RST;
              end
              default: mode_q <= mode_q;
            endcase
          end
        end
        SSLC_LOW_NIB: begin
          addr_q  <= addr_q + ADDR_ONE;
          drain_q <= SSLC_IDLE;
        end
        default: drain_q <= SSLC_IDLE;
      endcase
    end
  end

  a_addr_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pop && drain_q == SSLC_IDLE |=> addr_q == $past(addr_q))
    else $error("address counter moved with no word");
  a_mode_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(pop && is_cmd) |=> mode_q == $past(mode_q))
    else $error("display mode changed with no command");
  a_addr_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    drain_q == SSLC_LOW_NIB && addr_q == '1 |=> addr_q == ADDR_RST)
    else $error("address counter did not wrap to zero");

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        display_ram[i] <= 4'h0;
      end
    end else if (pop && !is_cmd) begin
      display_ram[addr_q] <= head[7:4];
    end else if (drain_q == SSLC_LOW_NIB) begin
      display_ram[addr_q] <= low_nib_q;
    end else if (pop && is_op(head, OP_REWRITE)) begin
      display_ram[addr_q] <= head[3:0];
    end
  end

  a_hi_nib: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop && !is_cmd |=> display_ram[$past(addr_q)] == $past(head[7:4]))
    else $error("high nibble not at the current address");
  a_lo_nib: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop && !is_cmd |=> ##1 display_ram[$past(addr_q, 2) + ADDR_ONE] == $past(head[3:0], 2))
    else $error("low nibble not at the next address");
  a_keep_ram: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop && (is_op(head, OP_DISP_ON) || is_op(head, OP_DISP_OFF)) |=>
      display_ram[$past(addr_q)] == $past(display_ram[addr_q]))
    else $error("display on or off changed the RAM");

  // Common phase and drive waveforms
  logic [1:0]         phase_q;
  logic [NUM_SEG-1:0] seg_d;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else if (osc_rise) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  a_phase_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !osc_rise |=> phase_q == $past(phase_q))
    else $error("common phase moved without an oscillator edge");
  a_phase_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    osc_rise |=> phase_q == $past(phase_q) + 2'h1)
    else $error("common phase did not step");

  // COM0 takes the MSB of each RAM word
  // One segment level for the mode; the RAM bit only counts in RAM mode
  function automatic logic seg_level(input sslc_mode_e mode, input logic ram_bit);
    logic lvl;
    case (mode)
      SSLC_ALL_ON:   lvl = 1'b1;
      SSLC_FROM_RAM: lvl = ram_bit;
      default:       lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
    assign seg_d[s] = seg_level(mode_q, display_ram[s][2'h3 - phase_q]);
  end

  // Drive outputs are registered so the pins never glitch as the phase moves
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      common_outputs <= COM_RST;
    end else begin
      common_outputs <= COM_RST << phase_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      segment_outputs <= '0;
    end else begin
      segment_outputs <= seg_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_counter_bits <= ADDR_RST;
    end else begin
      address_counter_bits <= addr_q;
    end
  end

  // Oscillator return pin; idles high while the input is held low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_out <= 1'b1;
    end else begin
      osc_out <= ~osc_q[1];
    end
  end

  a_ram_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_q == SSLC_FROM_RAM && phase_q == 2'h0 |=>
      segment_outputs[0] == $past(display_ram[0][3]))
    else $error("segment drive does not follow the RAM on the first common");

  // Checks
  a_frame_push: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push |=> bit_cnt_q == 3'h0)
    else $error("bit count did not restart after the eighth edge");
  a_cs_discard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_q[1] |=> bit_cnt_q == 3'h0)
    else $error("bit count kept while deselected");
  a_addr_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop && is_cmd && opcode == OP_ADDR_SET |=> addr_q == $past(head[4:0]))
    else $error("address set not loaded");
  a_all_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_q == SSLC_ALL_ON |=> segment_outputs == '1)
    else $error("display on left a segment dark");
  a_all_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_q == SSLC_OFF |=> segment_outputs == '0)
    else $error("display off left a segment lit");
  a_rewrite_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop && is_cmd && opcode == OP_REWRITE |=>
      addr_q == $past(addr_q) + ADDR_ONE && display_ram[$past(addr_q)] == $past(head[3:0]))
    else $error("rewrite wrong");
  a_word_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop && !is_cmd |=> ##1 addr_q == $past(addr_q, 2) + 5'h02)
    else $error("data word did not advance by two");
  a_reset_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pop && is_cmd && opcode == OP_RESET |=> mode_q == SSLC_OFF && addr_q == ADDR_RST)
    else $error("reset command incomplete");
  a_common_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot(common_outputs))
    else $error("common select not one-hot");

  c_data_word: cover property (@(posedge ref_clk) disable iff (!rst_n) pop && !is_cmd);
  c_rewrite:   cover property (@(posedge ref_clk) disable iff (!rst_n)
    pop && is_cmd && opcode == OP_REWRITE);
  c_reset_cmd: cover property (@(posedge ref_clk) disable iff (!rst_n)
    pop && is_cmd && opcode == OP_RESET);
  c_buf_full:  cover property (@(posedge ref_clk) disable iff (!rst_n) buf_full);
  c_addr_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
    drain_q == SSLC_LOW_NIB && addr_q == '1);
endmodule
`default_nettype wire

// *** verif/sslc_host.sv ***
// Purpose: host model driving the serial command port
// Assumes: HALF ref_clk cycles per shift clock half period
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module sslc_host #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output var logic  sck,
  output var logic  cs_n,
  output var logic  cd_sel,
  output var logic  serial_in
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    cd_sel = 1'b0;
    serial_in = 1'b0;
  end

  // Sends the top n bits of w; fewer than eight leaves a partial word
  // Each bit takes exactly 2*HALF cycles, so the shift clock period is exact
  task automatic send_bits(input logic cmd, input logic [7:0] w, input int n);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    cd_sel <= cmd;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      serial_in <= w[7-i];
      repeat (HALF) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
    end
    sck <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    cs_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (HALF) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** verif/sslc_top_tb.sv ***
// Purpose: self-checking bench for the serial segment LCD controller
// Assumes: osc_in toggles every 30 ref_clk cycles, free of the serial link
// Notes:   the decoder stalls only one cycle per data word, so the word buffer cannot be filled here
`timescale 1ns/1ps
`default_nettype none
module sslc_top_tb;
  import sslc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n;
  logic        sck;
  logic        cs_n;
  logic        cd_sel;
  logic        serial_in;
  logic        osc_in;
  logic        osc_out;
  logic        buf_ready;
  logic [3:0]  common_outputs;
  logic [31:0] segment_outputs;
  logic [4:0]  address_counter_bits;
  int          osc_cnt;
  int          err_total;
  int          n_compared;
  int          m_addr;
  int          m_mode;
  logic [3:0]  m_ram [32];

  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    osc_cnt <= (osc_cnt == 29) ? 0 : osc_cnt + 1;
    if (osc_cnt == 29) osc_in <= ~osc_in;
  end

  sslc_host u_host (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n), .cd_sel(cd_sel),
                    .serial_in(serial_in));

  sslc_top #(.DEPTH(2)) u_sslc_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .cd_sel(cd_sel),
    .serial_in(serial_in), .osc_in(osc_in), .osc_out(osc_out), .buf_ready(buf_ready),
    .common_outputs(common_outputs), .segment_outputs(segment_outputs),
    .address_counter_bits(address_counter_bits));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Sends one word and mirrors its effect in the model
  task automatic do_word(input logic cmd, input logic [7:0] w);
    u_host.send_bits(cmd, w, 8);
    if (!cmd) begin
      m_ram[m_addr] = w[7:4];
      m_ram[(m_addr + 1) % 32] = w[3:0];
      m_addr = (m_addr + 2) % 32;
    end else begin
      case (w[7:5])
        OP_ADDR_SET: m_addr = w[4:0];
        OP_DISP_ON:  m_mode = 1;
        OP_DISP_OFF: m_mode = 0;
        OP_DISP_RUN: m_mode = 2;
        OP_REWRITE: begin
          m_ram[m_addr] = w[3:0];
          m_addr = (m_addr + 1) % 32;
        end
        OP_RESET: begin
          m_mode = 0;
          m_addr = 0;
        end
        default: ;
      endcase
    end
    repeat (10) @(negedge ref_clk);
    check("address", 32'(address_counter_bits), 32'(m_addr));
    check("buf_ready", 32'(buf_ready), 32'h1);
  endtask

  function automatic logic [31:0] seg_exp(input int p);
    logic [31:0] s;
    for (int k = 0; k < 32; k++) s[k] = (m_mode == 2) ? m_ram[k][3-p] : (m_mode == 1);
    return s;
  endfunction

  // Follows four common steps and checks drive at each
  task automatic check_phases();
    logic [3:0] old;
    logic [3:0] nxt;
    int         n;
    int         p;
    for (int ph = 0; ph < 4; ph++) begin
      old = common_outputs;
      nxt = {old[2:0], old[3]};
      n = 0;
      while (common_outputs === old && n < 400) begin
        @(negedge ref_clk);
        n++;
      end
      if (n >= 400) begin
        err_total++;
        results();
      end
      repeat (4) @(negedge ref_clk);
      for (int k = 0; k < 4; k++) if (nxt[k]) p = k;
      check("commons", 32'(common_outputs), 32'(nxt));
      check("segments", segment_outputs, seg_exp(p));
      check("osc_out", 32'(osc_out), 32'(!osc_in));
    end
  endtask

  initial begin
    rst_n = 1'b0;
    osc_in = 1'b0;
    osc_cnt = 0;
    err_total = 0;
    n_compared = 0;
    m_addr = 0;
    m_mode = 0;
    for (int k = 0; k < 32; k++) m_ram[k] = 4'h0;
    void'($urandom(70359));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    check("address", 32'(address_counter_bits), 32'h0);
    check("segments", segment_outputs, 32'h0);
    check("buf_ready", 32'(buf_ready), 32'h1);
    do_word(1'b1, 8'hC0);
    do_word(1'b1, 8'h1E);
    do_word(1'b0, 8'($urandom));
    do_word(1'b1, 8'h1F);
    do_word(1'b1, 8'h95);
    u_host.send_bits(1'b1, 8'h05, 5);
    repeat (10) @(negedge ref_clk);
    check("address", 32'(address_counter_bits), 32'(m_addr));
    do_word(1'b1, 8'h0A);
    check_phases();
    do_word(1'b1, 8'h00);
    for (int k = 0; k < 16; k++) do_word(1'b0, 8'($urandom));
    do_word(1'b1, 8'h7F);
    check_phases();
    do_word(1'b1, 8'h20);
    check_phases();
    do_word(1'b1, 8'h40);
    check_phases();
    do_word(1'b1, 8'hBF);
    do_word(1'b1, 8'h60);
    check_phases();
    do_word(1'b1, 8'h03);
    do_word(1'b1, 8'hDF);
    check_phases();
    results();
  end
endmodule
`default_nettype wire
